// ### logic/cafc_core.sv
// Execution datapath: ALU, multiply, flow control timing and I/O address decode.
`default_nettype none
// Behaviour
// - I/O 0x00-0x1F support bit set, bit clear and skip-on-bit tests.
// - Bit set and clear write only the addressed bit, via a one-hot mask.
// - Port instructions reach I/O 0x00-0x3F; data space sees them at +0x20.
// - Extended I/O 0x60-0xFF is reached only by data-space load and store.
// - Register add, with or without carry, one clock, flags Z C N V H.
// - Pair immediate add and subtract take two clocks, flags Z C N V S.
// - Subtract register or constant, with or without borrow, one clock, Z C N V H.
// - AND, OR, XOR take one clock and update only Z N V.
// - Invert gives 0xFF minus operand (Z C N V); negate gives 0x00 minus (plus H).
// - Set-bits ORs mask, clear-bits ANDs with inverted mask, flags Z N V.
// - Increment, decrement, probe and clear take one clock, flags Z N V.
// - Integer multiplies write 16-bit product to R1:R0 in two clocks, Z and C.
// - Fractional multiplies shift the product left once, two clocks, Z and C.
// - Relative jump PC+k+1 and Z jump take two clocks, absolute jump three.
// - Relative call three clocks, absolute call four, return four; no flags.
module cafc_core (
  input  wire logic               CLK_SYS_I,
  input  wire logic               SYS_RST_I,
  input  wire logic               OP_VALID_I,
  input  wire cafc_pkg::cafc_op_e OP_CODE_I,
  input  wire logic [7:0]         OPA_I,
  input  wire logic [7:0]         OPB_I,
  input  wire logic [15:0]        WORD_I,
  input  wire logic [7:0]         IO_RDATA_I,
  output logic                    BUSY_O,
  output logic                    DONE_O,
  output logic [15:0]             RES_O,
  output logic                    RD_WE_O,
  output logic                    PAIR_WE_O,
  output logic                    PROD_WE_O,
  output logic                    PUSH_O,
  output logic [7:0]              SREG_O,
  output logic [15:0]             PC_O,
  output logic [7:0]              IO_ADDR_O,
  output logic                    IO_RE_O,
  output logic                    IO_WE_O,
  output logic [7:0]              IO_WMASK_O,
  output logic [7:0]              IO_WDATA_O,
  output logic                    IO_ERR_O,
  output logic                    SKIP_O
);
  // ****************************************************************
  // Sequencing
  // ****************************************************************
  cafc_mul_if          mul ();
  cafc_pkg::cafc_op_e  cur_op;
  cafc_pkg::cafc_op_e  op;
  logic [7:0]          cur_a;
  logic [7:0]          cur_b;
  logic [15:0]         cur_w;
  logic [2:0]          cnt;
  logic [2:0]          cycles;
  logic                busy;
  logic                take;
  logic                finish;
  logic [7:0]          a;
  logic [7:0]          b;
  logic [15:0]         w;
  logic [7:0]          sreg;
  logic [15:0]         pc;

  assign take   = OP_VALID_I & ~busy;
  assign op     = busy ? cur_op : OP_CODE_I;
  assign a      = busy ? cur_a : OPA_I;
  assign b      = busy ? cur_b : OPB_I;
  assign w      = busy ? cur_w : WORD_I;
  assign finish = (take && cycles == cafc_pkg::CAFC_CYC_ONE) || (busy && cnt == 3'h1);

  always_comb begin
    case (op)
      cafc_pkg::op_pair_immediate_sum,
      cafc_pkg::op_pair_immediate_minus:      cycles = cafc_pkg::CAFC_CYC_PAIR;
      cafc_pkg::op_unsigned_product, cafc_pkg::op_signed_product,
      cafc_pkg::op_mixed_sign_product, cafc_pkg::op_frac_unsigned_product,
      cafc_pkg::op_frac_signed_product,
      cafc_pkg::op_frac_mixed_product:        cycles = cafc_pkg::CAFC_CYC_MUL;
      cafc_pkg::op_pc_relative_jump:          cycles = cafc_pkg::CAFC_CYC_RJUMP;
      cafc_pkg::op_z_pointer_jump:            cycles = cafc_pkg::CAFC_CYC_ZJUMP;
      cafc_pkg::op_absolute_jump:             cycles = cafc_pkg::CAFC_CYC_AJUMP;
      cafc_pkg::op_relative_subroutine_entry: cycles = cafc_pkg::CAFC_CYC_RELATIVE_SUBROUTINE_ENTRY;
      cafc_pkg::op_absolute_call:             cycles = cafc_pkg::CAFC_CYC_ACALL;
      cafc_pkg::op_subroutine_exit:           cycles = cafc_pkg::CAFC_CYC_EXIT;
      default:                                cycles = cafc_pkg::CAFC_CYC_ONE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      busy   <= 1'b0;
      cnt    <= 3'h0;
      cur_op <= cafc_pkg::op_add;
      cur_a  <= 8'h00;
      cur_b  <= 8'h00;
      cur_w  <= 16'h0000;
    end else if (take && cycles != cafc_pkg::CAFC_CYC_ONE) begin
      busy   <= 1'b1;
      cnt    <= cycles - 3'h1;
      cur_op <= OP_CODE_I;
      cur_a  <= OPA_I;
      cur_b  <= OPB_I;
      cur_w  <= WORD_I;
    end else if (busy) begin
      cnt  <= cnt - 3'h1;
      busy <= (cnt != 3'h1);
    end
  end

  // ****************************************************************
  // Multiplier
  // ****************************************************************
  logic is_mul_s;
  logic is_mul_mix;
  logic is_frac;

  assign is_mul_s   = op == cafc_pkg::op_signed_product || op == cafc_pkg::op_frac_signed_product;
  assign is_mul_mix = op == cafc_pkg::op_mixed_sign_product ||
                      op == cafc_pkg::op_frac_mixed_product;
  assign is_frac    = op == cafc_pkg::op_frac_unsigned_product ||
                      op == cafc_pkg::op_frac_signed_product || op == cafc_pkg::op_frac_mixed_product;
  assign mul.start    = take && cycles == cafc_pkg::CAFC_CYC_MUL &&
                        (is_frac || is_mul_s || is_mul_mix || op == cafc_pkg::op_unsigned_product);
  assign mul.a        = OPA_I;
  assign mul.b        = OPB_I;
  assign mul.a_signed = is_mul_s | is_mul_mix;
  assign mul.b_signed = is_mul_s;
  assign mul.frac     = is_frac;

  cafc_mul u_mul (
    .clk_i (CLK_SYS_I),
    .rst_i (SYS_RST_I),
    .mul   (mul.unit)
  );

  // ****************************************************************
  // Arithmetic and I/O decode
  // ****************************************************************
  logic       c_in;
  logic [8:0] add9;
  logic [8:0] sub9;
  logic [15:0] wsum;
  logic [15:0] wdif;
  logic [7:0] bit_mask;
  logic       port_ok;
  logic       bit_ok;
  logic       data_io;
  logic [15:0] data_idx;

  assign c_in  = sreg[cafc_pkg::CAFC_FLAG_C];
  assign add9  = {1'b0, a} + {1'b0, b} + {8'h00, c_in & (op == cafc_pkg::op_add_carry)};
  assign sub9  = {1'b0, a} - {1'b0, b} - {8'h00, c_in & (op == cafc_pkg::op_minus_with_carry)};
  assign wsum  = w + {10'h000, b[5:0]};
  assign wdif  = w - {10'h000, b[5:0]};
  assign bit_mask = 8'h01 << b[2:0];
  assign port_ok  = w <= cafc_pkg::CAFC_PORT_IO_LAST;
  assign bit_ok   = w <= cafc_pkg::CAFC_BIT_IO_LAST;
  assign data_io  = w >= cafc_pkg::CAFC_DATA_IO_OFS && w <= cafc_pkg::CAFC_EXT_IO_LAST;
  assign data_idx = w - cafc_pkg::CAFC_DATA_IO_OFS;

  logic [15:0] n_res;
  logic [15:0] n_pc;
  logic [7:0]  n_fl;
  logic [7:0]  n_mask;
  logic [7:0]  n_ioa;
  logic [7:0]  n_iom;
  logic [7:0]  n_iod;
  logic        n_rd;
  logic        n_pair;
  logic        n_prod;
  logic        n_push;
  logic        n_re;
  logic        n_we;
  logic        n_err;
  logic        n_skip;
  logic        n_zchain;

  always_comb begin
    n_res = 16'h0000; n_pc = pc + 16'h0001; n_fl = 8'h00;
    n_mask = cafc_pkg::CAFC_MASK_NONE;
    n_ioa = 8'h00; n_iom = 8'h00; n_iod = 8'h00; n_zchain = 1'b0;
    n_rd = 1'b0; n_pair = 1'b0; n_prod = 1'b0; n_push = 1'b0;
    n_re = 1'b0; n_we = 1'b0; n_err = 1'b0; n_skip = 1'b0;
    case (op)
      cafc_pkg::op_add, cafc_pkg::op_add_carry: begin
        n_res = {8'h00, add9[7:0]}; n_rd = 1'b1; n_mask = cafc_pkg::CAFC_MASK_ARITH;
        n_fl[cafc_pkg::CAFC_FLAG_H] = a[3]&b[3] | b[3]&~add9[3] | ~add9[3]&a[3];
        n_fl[cafc_pkg::CAFC_FLAG_V] = a[7]&b[7]&~add9[7] | ~a[7]&~b[7]&add9[7];
        n_fl[cafc_pkg::CAFC_FLAG_C] = add9[8];
      end
      cafc_pkg::op_sub, cafc_pkg::op_minus_with_carry: begin
        n_res = {8'h00, sub9[7:0]}; n_rd = 1'b1; n_mask = cafc_pkg::CAFC_MASK_ARITH;
        n_fl[cafc_pkg::CAFC_FLAG_H] = ~a[3]&b[3] | b[3]&sub9[3] | sub9[3]&~a[3];
        n_fl[cafc_pkg::CAFC_FLAG_V] = a[7]&~b[7]&~sub9[7] | ~a[7]&b[7]&sub9[7];
        n_fl[cafc_pkg::CAFC_FLAG_C] = sub9[8];
        n_zchain = op == cafc_pkg::op_minus_with_carry;
      end
      cafc_pkg::op_and, cafc_pkg::op_zero_sign_probe: begin
        n_res = {8'h00, a & b}; n_rd = 1'b1; n_mask = cafc_pkg::CAFC_MASK_LOGIC;
      end
      cafc_pkg::op_or, cafc_pkg::op_set_bits_mask: begin
        n_res = {8'h00, a | b}; n_rd = 1'b1; n_mask = cafc_pkg::CAFC_MASK_LOGIC;
      end
      cafc_pkg::op_clear_bits_mask: begin
        n_res = {8'h00, a & (8'hff - b)}; n_rd = 1'b1; n_mask = cafc_pkg::CAFC_MASK_LOGIC;
      end
      cafc_pkg::op_exclusive_merge, cafc_pkg::op_zero_register: begin
        n_res = {8'h00, a ^ b}; n_rd = 1'b1; n_mask = cafc_pkg::CAFC_MASK_LOGIC;
      end
      cafc_pkg::op_bitwise_invert: begin
        n_res = {8'h00, 8'hff - a}; n_rd = 1'b1; n_mask = cafc_pkg::CAFC_MASK_INV;
        n_fl[cafc_pkg::CAFC_FLAG_C] = 1'b1;
      end
      cafc_pkg::op_zero_minus_value: begin
        n_res = {8'h00, 8'h00 - a}; n_rd = 1'b1; n_mask = cafc_pkg::CAFC_MASK_ARITH;
        n_fl[cafc_pkg::CAFC_FLAG_H] = n_res[3] | a[3];
        n_fl[cafc_pkg::CAFC_FLAG_V] = n_res[7:0] == 8'h80;
        n_fl[cafc_pkg::CAFC_FLAG_C] = n_res[7:0] != 8'h00;
      end
      cafc_pkg::op_plus_one, cafc_pkg::op_minus_one: begin
        n_res = {8'h00, op == cafc_pkg::op_plus_one ? a + 8'h01 : a - 8'h01};
        n_rd = 1'b1; n_mask = cafc_pkg::CAFC_MASK_LOGIC;
        n_fl[cafc_pkg::CAFC_FLAG_V] = op == cafc_pkg::op_plus_one ? n_res[7:0] == 8'h80
                                                                   : n_res[7:0] == 8'h7f;
      end
      cafc_pkg::op_all_ones_register: begin
        n_res = 16'h00ff; n_rd = 1'b1;
      end
      cafc_pkg::op_pair_immediate_sum, cafc_pkg::op_pair_immediate_minus: begin
        n_res = op == cafc_pkg::op_pair_immediate_sum ? wsum : wdif;
        n_pair = 1'b1; n_mask = cafc_pkg::CAFC_MASK_WORD;
        n_fl[cafc_pkg::CAFC_FLAG_V] = op == cafc_pkg::op_pair_immediate_sum ?
                                      ~w[15] & n_res[15] : w[15] & ~n_res[15];
        n_fl[cafc_pkg::CAFC_FLAG_C] = op == cafc_pkg::op_pair_immediate_sum ?
                                      ~n_res[15] & w[15] : n_res[15] & ~w[15];
        n_fl[cafc_pkg::CAFC_FLAG_S] = n_res[15] ^ n_fl[cafc_pkg::CAFC_FLAG_V];
      end
      cafc_pkg::op_unsigned_product, cafc_pkg::op_signed_product,
      cafc_pkg::op_mixed_sign_product, cafc_pkg::op_frac_unsigned_product,
      cafc_pkg::op_frac_signed_product, cafc_pkg::op_frac_mixed_product: begin
        n_res = mul.prod; n_prod = 1'b1; n_mask = cafc_pkg::CAFC_MASK_MUL;
        n_fl[cafc_pkg::CAFC_FLAG_C] = mul.carry;
      end
      cafc_pkg::op_pc_relative_jump: n_pc = pc + w + 16'h0001;
      cafc_pkg::op_z_pointer_jump, cafc_pkg::op_absolute_jump,
      cafc_pkg::op_subroutine_exit: n_pc = w;
      cafc_pkg::op_relative_subroutine_entry: begin
        n_pc = pc + w + 16'h0001; n_res = pc + 16'h0001; n_push = 1'b1;
      end
      cafc_pkg::op_absolute_call: begin
        n_pc = w; n_res = pc + 16'h0002; n_push = 1'b1;
      end
      cafc_pkg::op_io_port_read, cafc_pkg::op_io_port_write: begin
        n_ioa = w[7:0]; n_err = ~port_ok; n_iom = 8'hff; n_iod = a;
        n_re = port_ok & (op == cafc_pkg::op_io_port_read);
        n_we = port_ok & (op == cafc_pkg::op_io_port_write);
        n_rd = n_re; n_res = {8'h00, IO_RDATA_I};
      end
      cafc_pkg::op_load_op, cafc_pkg::op_write_mem_op: begin
        n_ioa = data_idx[7:0]; n_iom = 8'hff; n_iod = a;
        n_re = data_io & (op == cafc_pkg::op_load_op);
        n_we = data_io & (op == cafc_pkg::op_write_mem_op);
        n_rd = n_re; n_res = {8'h00, IO_RDATA_I};
      end
      cafc_pkg::op_io_bit_set_op, cafc_pkg::op_io_bit_clear_op: begin
        n_ioa = w[7:0]; n_err = ~bit_ok; n_we = bit_ok; n_iom = bit_mask;
        n_iod = op == cafc_pkg::op_io_bit_set_op ? bit_mask : 8'h00;
      end
      cafc_pkg::op_skip_if_io_bit_one, cafc_pkg::op_skip_if_io_bit_zero: begin
        n_ioa = w[7:0]; n_err = ~bit_ok;
        n_skip = bit_ok & (IO_RDATA_I[b[2:0]] == (op == cafc_pkg::op_skip_if_io_bit_one));
      end
      default: n_res = 16'h0000;
    endcase
    // The borrow chain lets a multi-byte subtract report zero only when every byte was zero.
    n_fl[cafc_pkg::CAFC_FLAG_Z] = n_pair || n_prod ? n_res == 16'h0000 :
                                  (n_res[7:0] == 8'h00) & (~n_zchain | sreg[cafc_pkg::CAFC_FLAG_Z]);
    n_fl[cafc_pkg::CAFC_FLAG_N] = n_pair ? n_res[15] : n_res[7];
  end

  // ****************************************************************
  // Result registers
  // ****************************************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      sreg <= cafc_pkg::CAFC_SREG_RESET; pc <= 16'h0000; RES_O <= 16'h0000;
      IO_ADDR_O <= 8'h00; IO_WMASK_O <= 8'h00; IO_WDATA_O <= 8'h00;
    end else if (finish) begin
      sreg <= (sreg & ~n_mask) | (n_fl & n_mask);
      pc <= n_pc; RES_O <= n_res;
      IO_ADDR_O <= n_ioa; IO_WMASK_O <= n_iom; IO_WDATA_O <= n_iod;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      {DONE_O, RD_WE_O, PAIR_WE_O, PROD_WE_O, PUSH_O} <= 5'h00;
      {IO_RE_O, IO_WE_O, IO_ERR_O, SKIP_O} <= 4'h0;
    end else begin
      {DONE_O, RD_WE_O, PAIR_WE_O, PROD_WE_O, PUSH_O} <=
        {finish, finish & n_rd, finish & n_pair, finish & n_prod, finish & n_push};
      {IO_RE_O, IO_WE_O, IO_ERR_O, SKIP_O} <=
        {finish & n_re, finish & n_we, finish & n_err, finish & n_skip};
    end
  end

  assign BUSY_O = busy;
  assign SREG_O = sreg;
  assign PC_O   = pc;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  a_add_one_clock: assert property (take && OP_CODE_I == cafc_pkg::op_add
    |=> DONE_O && RD_WE_O) else $error("add did not finish in one clock");
  a_pair_two_clock: assert property (take && OP_CODE_I == cafc_pkg::op_pair_immediate_sum
    |=> !DONE_O ##1 DONE_O && PAIR_WE_O) else $error("pair sum timing wrong");
  a_sub_keeps_s: assert property (take && OP_CODE_I == cafc_pkg::op_sub
    |=> SREG_O[4] == $past(SREG_O[4])) else $error("subtract touched S");
  a_logic_flags: assert property (take && OP_CODE_I == cafc_pkg::op_or
    |=> !SREG_O[3] && SREG_O[0] == $past(SREG_O[0])) else $error("logic flags wrong");
  a_invert_value: assert property (take && OP_CODE_I == cafc_pkg::op_bitwise_invert
    |=> RES_O[7:0] == ~$past(OPA_I) && SREG_O[0]) else $error("invert wrong");
  a_clear_mask: assert property (take && OP_CODE_I == cafc_pkg::op_clear_bits_mask
    |=> RES_O[7:0] == ($past(OPA_I) & ~$past(OPB_I))) else $error("clear bits wrong");
  a_inc_keeps_c: assert property (take && OP_CODE_I == cafc_pkg::op_plus_one
    |=> SREG_O[0] == $past(SREG_O[0])) else $error("increment touched C");
  a_mul_product: assert property (take && OP_CODE_I == cafc_pkg::op_unsigned_product
    |=> !DONE_O ##1 PROD_WE_O && RES_O == $past(OPA_I, 2) * $past(OPB_I, 2))
    else $error("unsigned product wrong");
  a_abs_jump_time: assert property (take && OP_CODE_I == cafc_pkg::op_absolute_jump
    |=> !DONE_O [*2] ##1 DONE_O && PC_O == $past(WORD_I, 3)) else $error("jump timing wrong");
  a_call_four: assert property (take && OP_CODE_I == cafc_pkg::op_absolute_call
    |-> ##4 DONE_O && PUSH_O && SREG_O == $past(SREG_O, 4)) else $error("call timing wrong");
  a_ones_no_flag: assert property (take && OP_CODE_I == cafc_pkg::op_all_ones_register
    |=> SREG_O == $past(SREG_O)) else $error("set all ones changed flags");
  a_bit_set_mask: assert property (take && OP_CODE_I == cafc_pkg::op_io_bit_set_op &&
    WORD_I <= 16'h001f |=> IO_WE_O && IO_WMASK_O == 8'h01 << $past(OPB_I[2:0]))
    else $error("bit set mask wrong");
  a_ext_port_refused: assert property (take && OP_CODE_I == cafc_pkg::op_io_port_write &&
    WORD_I > 16'h003f |=> !IO_WE_O && IO_ERR_O) else $error("port reached extended I/O");
  a_data_offset: assert property (take && OP_CODE_I == cafc_pkg::op_load_op &&
    WORD_I >= 16'h0020 && WORD_I <= 16'h005f |=> IO_RE_O && IO_ADDR_O == $past(WORD_I[7:0]) - 8'h20)
    else $error("data space offset wrong");
endmodule
`default_nettype wire

// ### logic/cafc_pkg.sv
// Shared constants, flag layout, cycle counts and operation codes of the execution datapath.
`default_nettype none
package cafc_pkg;
  // ****************************************************************
  // I/O address map
  // ****************************************************************
  localparam logic [15:0] CAFC_BIT_IO_LAST  = 16'h001f;
  localparam logic [15:0] CAFC_PORT_IO_LAST = 16'h003f;
  localparam logic [15:0] CAFC_DATA_IO_OFS  = 16'h0020;
  localparam logic [15:0] CAFC_EXT_IO_FIRST = 16'h0060;
  localparam logic [15:0] CAFC_EXT_IO_LAST  = 16'h00ff;

  // ****************************************************************
  // Status flag positions, masks and reset value
  // ****************************************************************
  localparam int          CAFC_FLAG_C     = 0;
  localparam int          CAFC_FLAG_Z     = 1;
  localparam int          CAFC_FLAG_N     = 2;
  localparam int          CAFC_FLAG_V     = 3;
  localparam int          CAFC_FLAG_S     = 4;
  localparam int          CAFC_FLAG_H     = 5;
  localparam logic [7:0]  CAFC_SREG_RESET = 8'h00;
  localparam logic [7:0]  CAFC_MASK_ARITH = 8'h2f;
  localparam logic [7:0]  CAFC_MASK_WORD  = 8'h1f;
  localparam logic [7:0]  CAFC_MASK_LOGIC = 8'h0e;
  localparam logic [7:0]  CAFC_MASK_INV   = 8'h0f;
  localparam logic [7:0]  CAFC_MASK_MUL   = 8'h03;
  localparam logic [7:0]  CAFC_MASK_NONE  = 8'h00;

  // ****************************************************************
  // Cycle counts
  // ****************************************************************
  localparam logic [2:0]  CAFC_CYC_ONE    = 3'h1;
  localparam logic [2:0]  CAFC_CYC_PAIR   = 3'h2;
  localparam logic [2:0]  CAFC_CYC_MUL    = 3'h2;
  localparam logic [2:0]  CAFC_CYC_RJUMP  = 3'h2;
  localparam logic [2:0]  CAFC_CYC_ZJUMP  = 3'h2;
  localparam logic [2:0]  CAFC_CYC_AJUMP  = 3'h3;
  localparam logic [2:0]  CAFC_CYC_RELATIVE_SUBROUTINE_ENTRY  = 3'h3;
  localparam logic [2:0]  CAFC_CYC_ACALL  = 3'h4;
  localparam logic [2:0]  CAFC_CYC_EXIT   = 3'h4;

  // ****************************************************************
  // Operations
  // ****************************************************************
  typedef enum logic [5:0] {
    op_add, op_add_carry, op_sub, op_minus_with_carry,
    op_and, op_or, op_exclusive_merge, op_bitwise_invert, op_zero_minus_value,
    op_set_bits_mask, op_clear_bits_mask, op_plus_one, op_minus_one,
    op_zero_sign_probe, op_zero_register, op_all_ones_register,
    op_pair_immediate_sum, op_pair_immediate_minus,
    op_unsigned_product, op_signed_product, op_mixed_sign_product,
    op_frac_unsigned_product, op_frac_signed_product, op_frac_mixed_product,
    op_pc_relative_jump, op_z_pointer_jump, op_absolute_jump,
    op_relative_subroutine_entry, op_absolute_call, op_subroutine_exit,
    op_io_port_read, op_io_port_write, op_load_op, op_write_mem_op,
    op_io_bit_set_op, op_io_bit_clear_op, op_skip_if_io_bit_one, op_skip_if_io_bit_zero
  } cafc_op_e;
endpackage
`default_nettype wire

// ### logic/cafc_mul_if.sv
// Interface between the datapath and its two-clock multiplier.
`default_nettype none
interface cafc_mul_if;
  logic        start;
  logic [7:0]  a;
  logic [7:0]  b;
  logic        a_signed;
  logic        b_signed;
  logic        frac;
  logic [15:0] prod;
  logic        carry;
  modport master (output start, a, b, a_signed, b_signed, frac, input prod, carry);
  modport unit   (input start, a, b, a_signed, b_signed, frac, output prod, carry);
endinterface
`default_nettype wire

// ### logic/cafc_mul.sv
// Two-clock 8x8 multiplier with signed, mixed and fractional modes.
`default_nettype none
module cafc_mul (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  cafc_mul_if.unit    mul
);
  logic              a_sg;
  logic              b_sg;
  logic              frac;
  logic [7:0]        a;
  logic [7:0]        b;
  logic signed [8:0] ext_a;
  logic signed [8:0] ext_b;
  logic signed [17:0] full;
  logic [15:0]       raw;

  // Operands are captured in the first clock; the product is ready in the second.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a    <= 8'h00;
      b    <= 8'h00;
      a_sg <= 1'b0;
      b_sg <= 1'b0;
      frac <= 1'b0;
    end else if (mul.start) begin
      a    <= mul.a;
      b    <= mul.b;
      a_sg <= mul.a_signed;
      b_sg <= mul.b_signed;
      frac <= mul.frac;
    end
  end

  assign ext_a    = {a_sg & a[7], a};
  assign ext_b    = {b_sg & b[7], b};
  assign full     = ext_a * ext_b;
  assign raw      = full[15:0];
  assign mul.prod = frac ? {raw[14:0], 1'b0} : raw;
  assign mul.carry = raw[15];

  a_frac_shift_left: assert property (@(posedge clk_i) disable iff (rst_i)
    mul.start && mul.frac |=> mul.prod == {raw[14:0], 1'b0})
    else $error("fractional product not shifted");
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking testbench for the execution datapath.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic               CLK_SYS_I = 1'b0;
  logic               SYS_RST_I = 1'b1;
  logic               OP_VALID_I = 1'b0;
  cafc_pkg::cafc_op_e OP_CODE_I = cafc_pkg::op_add;
  logic [7:0]         OPA_I = 8'h00, OPB_I = 8'h00, IO_RDATA_I = 8'h10;
  logic [15:0]        WORD_I = 16'h0000;
  logic               BUSY_O, DONE_O, RD_WE_O, PAIR_WE_O, PROD_WE_O, PUSH_O;
  logic               IO_RE_O, IO_WE_O, IO_ERR_O, SKIP_O;
  logic [15:0]        RES_O, PC_O, w, pc, p;
  logic [7:0]         SREG_O, IO_ADDR_O, IO_WMASK_O, IO_WDATA_O, a, b, s;
  logic [8:0]         e;
  cafc_pkg::cafc_op_e c;
  int                 bad_count = 0, checked = 0, seed = 99, i;
  cafc_pkg::cafc_op_e alu[12] = '{cafc_pkg::op_add, cafc_pkg::op_add_carry, cafc_pkg::op_sub,
    cafc_pkg::op_and, cafc_pkg::op_or, cafc_pkg::op_exclusive_merge, cafc_pkg::op_bitwise_invert,
    cafc_pkg::op_zero_minus_value, cafc_pkg::op_clear_bits_mask, cafc_pkg::op_minus_with_carry,
    cafc_pkg::op_plus_one, cafc_pkg::op_minus_one};
  cafc_pkg::cafc_op_e mul[6] = '{cafc_pkg::op_unsigned_product, cafc_pkg::op_signed_product,
    cafc_pkg::op_mixed_sign_product, cafc_pkg::op_frac_unsigned_product,
    cafc_pkg::op_frac_signed_product, cafc_pkg::op_frac_mixed_product};
  cafc_pkg::cafc_op_e fl[6] = '{cafc_pkg::op_pc_relative_jump, cafc_pkg::op_z_pointer_jump,
    cafc_pkg::op_absolute_jump, cafc_pkg::op_relative_subroutine_entry,
    cafc_pkg::op_absolute_call, cafc_pkg::op_subroutine_exit};
  int                 fc[6] = '{2, 2, 3, 3, 4, 4};

  cafc_core cafc_core_i (.CLK_SYS_I, .SYS_RST_I, .OP_VALID_I, .OP_CODE_I, .OPA_I, .OPB_I,
    .WORD_I, .IO_RDATA_I, .BUSY_O, .DONE_O, .RES_O, .RD_WE_O, .PAIR_WE_O, .PROD_WE_O, .PUSH_O,
    .SREG_O, .PC_O, .IO_ADDR_O, .IO_RE_O, .IO_WE_O, .IO_WMASK_O, .IO_WDATA_O, .IO_ERR_O, .SKIP_O);

  always #25 CLK_SYS_I = ~CLK_SYS_I;

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Issues one operation and counts clocks up to its completion pulse.
  task automatic run(cafc_pkg::cafc_op_e op, logic [7:0] x, logic [7:0] y, logic [15:0] wd,
                     int n);
    int k;
    OP_CODE_I = op;
    OPA_I = x;
    OPB_I = y;
    WORD_I = wd;
    OP_VALID_I = 1'b1;
    k = 1;
    @(posedge CLK_SYS_I);
    #5 OP_VALID_I = 1'b0;
    chk(16'(BUSY_O), 16'(n > 1));
    while (DONE_O !== 1'b1 && k < 9) begin
      @(posedge CLK_SYS_I);
      #5 k++;
    end
    chk(16'(k), 16'(n));
    if (k == 9) end_sim();
  endtask

  // Carry-in feeds add and subtract with carry; for logic, increment and decrement ops it is passed through, since the carry flag must survive.
  function automatic logic [8:0] alu_exp(cafc_pkg::cafc_op_e op, logic [7:0] x, logic [7:0] y,
                                         logic ci);
    case (op)
      cafc_pkg::op_add: return {1'b0, x} + {1'b0, y};
      cafc_pkg::op_add_carry: return {1'b0, x} + {1'b0, y} + {8'h00, ci};
      cafc_pkg::op_sub: return {1'b0, x} - {1'b0, y};
      cafc_pkg::op_minus_with_carry: return {1'b0, x} - {1'b0, y} - {8'h00, ci};
      cafc_pkg::op_plus_one: return {ci, x + 8'h01};
      cafc_pkg::op_minus_one: return {ci, x - 8'h01};
      cafc_pkg::op_and: return {ci, x & y};
      cafc_pkg::op_or: return {ci, x | y};
      cafc_pkg::op_exclusive_merge: return {ci, x ^ y};
      cafc_pkg::op_bitwise_invert: return {1'b1, 8'hff - x};
      cafc_pkg::op_zero_minus_value: return {x != 8'h00, 8'h00 - x};
      default: return {ci, x & (8'hff - y)};
    endcase
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge CLK_SYS_I);
    #5 SYS_RST_I = 1'b0;
    for (i = 0; i < 40; i++) begin
      c = alu[{$random(seed)} % 12];
      a = (i == 0) ? 8'hff : 8'($random(seed));
      b = (i == 0) ? 8'h01 : 8'($random(seed));
      s = SREG_O;
      run(c, a, b, 16'h0000, 1);
      e = alu_exp(c, a, b, s[0]);
      chk(RES_O, {8'h00, e[7:0]});
      chk(16'({RD_WE_O, SREG_O[0]}), 16'({1'b1, e[8]}));
      chk(16'(SREG_O[1]),
          16'(e[7:0] == 8'h00 && (c != cafc_pkg::op_minus_with_carry || s[1])));
    end
    for (i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'h00 : 8'($random(seed));
      b = 8'($random(seed));
      run(mul[i], a, b, 16'h0000, 2);
      if (i % 3 == 1) p = $signed(a) * $signed(b);
      else if (i % 3 == 2) p = $signed(a) * $signed({1'b0, b});
      else p = a * b;
      chk(16'(SREG_O[0]), 16'(p[15]));
      if (i > 2) p = p << 1;
      chk(RES_O, p);
      chk(16'({PROD_WE_O, SREG_O[1]}), 16'({1'b1, p == 16'h0000}));
    end
    for (i = 0; i < 2; i++) begin
      w = (i == 0) ? 16'hffff : 16'($random(seed));
      b = (i == 0) ? 8'h01 : 8'($random(seed)) & 8'h3f;
      c = i ? cafc_pkg::op_pair_immediate_minus : cafc_pkg::op_pair_immediate_sum;
      run(c, 8'h00, b, w, 2);
      p = i ? w - 16'(b) : w + 16'(b);
      chk(RES_O, p);
      chk(16'({PAIR_WE_O, SREG_O[1:0]}), 16'({1'b1, p == 16'h0000, i ? p > w : p < w}));
    end
    for (i = 0; i < 6; i++) begin
      s = SREG_O;
      pc = PC_O;
      w = 16'($random(seed));
      run(fl[i], 8'h00, 8'h00, w, fc[i]);
      chk(PC_O, (i == 0 || i == 3) ? pc + w + 16'h0001 : w);
      chk(16'(SREG_O), 16'(s));
      chk(16'(PUSH_O), 16'(i == 3 || i == 4));
      if (i == 3 || i == 4) chk(RES_O, pc + 16'(i - 2));
    end
    run(cafc_pkg::op_io_bit_set_op, 8'h00, 8'h05, 16'h001f, 1);
    chk(16'({IO_WE_O, IO_WMASK_O}), 16'h0120);
    run(cafc_pkg::op_io_bit_clear_op, 8'h00, 8'h07, 16'h0020, 1);
    chk(16'({IO_ERR_O, IO_WE_O}), 16'h0002);
    run(cafc_pkg::op_skip_if_io_bit_one, 8'h00, 8'h04, 16'h0003, 1);
    chk(16'(SKIP_O), 16'h0001);
    run(cafc_pkg::op_skip_if_io_bit_zero, 8'h00, 8'h03, 16'h0003, 1);
    chk(16'(SKIP_O), 16'h0001);
    run(cafc_pkg::op_io_port_read, 8'h00, 8'h00, 16'h003f, 1);
    chk(16'({IO_RE_O, RD_WE_O, IO_ADDR_O}), 16'h033f);
    run(cafc_pkg::op_load_op, 8'h00, 8'h00, 16'h0025, 1);
    chk({IO_ADDR_O, RES_O[7:0]}, 16'h0510);
    run(cafc_pkg::op_io_port_write, 8'h5a, 8'h00, 16'h0040, 1);
    chk(16'({IO_ERR_O, IO_WE_O}), 16'h0002);
    run(cafc_pkg::op_write_mem_op, 8'h3c, 8'h00, 16'h0060, 1);
    chk({IO_ADDR_O, IO_WDATA_O}, 16'h403c);
    run(cafc_pkg::op_load_op, 8'h00, 8'h00, 16'h00ff, 1);
    chk(16'({IO_RE_O, IO_ADDR_O}), 16'h01df);
    s = SREG_O;
    run(cafc_pkg::op_all_ones_register, 8'h12, 8'h00, 16'h0000, 1);
    chk({RES_O[7:0], SREG_O}, {8'hff, s});
    end_sim();
  end
endmodule
`default_nettype wire
